/* File: logic/tca_pkg.sv */
// Constants and carrier types for the thermal configuration and alert mask bank
//
// Contract
// [RL1] Signed local offset register is added to every local result, step 0.25 C.
// [RL2] Signed remote two offset register is added to every remote two result.
// [RL3] With lock set, writes to offsets and measurement control are ignored.
// [RL4] Bits 0 to 3 pick three-wire (0) or two-wire (1) fan sensing.
// [RL5] Bit 4 set averages several conversions per channel before updating.
// [RL6] Bit 5 set bypasses the voltage input attenuator.
// [RL7] Bit 6 set stops round robin, converts one selected channel only.
// [RL8] Select code picks 2.5 V, supply, remote 1, local or remote 2.
// [RL9] Test bit 2 set starts conversions from the external clock pin.
// [RL10] Bit 7 set enters shutdown; PWM outputs go to fan-off, polarity aware.
// [RL11] In shutdown, current duty cycle readback returns 0x00.
// [RL12] Alert mask bits 0,2,4,5,6 suppress alert for their channel.
// [RL13] Alert mask bit 7 suppresses alert for all status two conditions.
// [RL14] Alert mask bits 1 and 3 are stored with no function.
// [RL15] Alert mask, offsets and measurement control reset to zero.
// [RL16] Alert drives the shared pin only when alert pin mode is configured.
// [RL17] Masking suppresses only the alert; status bits still get set.
package tca_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] TCA_OFS_LOCAL_OFFSET  = 8'h71;
  localparam logic [7:0] TCA_OFS_REMOTE2_OFFSET = 8'h72;
  localparam logic [7:0] TCA_OFS_MEAS_CTRL     = 8'h73;
  localparam logic [7:0] TCA_OFS_ALERT_MASK    = 8'h74;
  localparam logic [7:0] TCA_OFS_LIMIT_STATUS  = 8'ha0;
  localparam logic [7:0] TCA_OFS_IRQ_STATUS    = 8'ha1;
  localparam logic [7:0] TCA_OFS_IRQ_MASK      = 8'ha2;
  localparam logic [7:0] TCA_RESET_VALUE       = 8'h00;

  // ----------------------------------------
  // Measurement control fields
  // ----------------------------------------
  localparam int TCA_BIT_AVG  = 4;
  localparam int TCA_BIT_BYPASS   = 5;
  localparam int TCA_BIT_SINGLE_CHANNEL_MODE     = 6;
  localparam int TCA_BIT_SHUTDOWN = 7;

  // ----------------------------------------
  // Alert mask fields
  // ----------------------------------------
  localparam int TCA_BIT_MASK_25V  = 0;
  localparam int TCA_BIT_MASK_VCC  = 2;
  localparam int TCA_BIT_MASK_REM1 = 4;
  localparam int TCA_BIT_MASK_LOC  = 5;
  localparam int TCA_BIT_MASK_REM2 = 6;
  localparam int TCA_BIT_MASK_ST2  = 7;
  localparam logic [7:0] TCA_CHAN_MASK_BITS = 8'h75;

  // ----------------------------------------
  // Interrupt status fields
  // ----------------------------------------
  localparam int TCA_IRQ_LOCAL_DONE  = 0;
  localparam int TCA_IRQ_REMOTE_DONE = 1;
  localparam int TCA_IRQ_LOCK_REJECT = 2;
  localparam int TCA_IRQ_LIMIT       = 3;

  // ----------------------------------------
  // Converter channel codes and timing
  // ----------------------------------------
  localparam logic [2:0] TCA_CH_25V  = 3'h0;
  localparam logic [2:0] TCA_CH_VCC  = 3'h2;
  localparam logic [2:0] TCA_CH_REM1 = 3'h5;
  localparam logic [2:0] TCA_CH_LOC  = 3'h6;
  localparam logic [2:0] TCA_CH_REM2 = 3'h7;
  localparam int TCA_CLK_HZ      = 40_000_000;
  localparam int TCA_SINGLE_CHANNEL_MODE_US     = 50;
  localparam int TCA_SINGLE_CHANNEL_MODE_CYCLES = TCA_CLK_HZ / 1_000_000 * TCA_SINGLE_CHANNEL_MODE_US;
  localparam int TCA_AVG_COUNT   = 16;

  // ----------------------------------------
  // Register bus request
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tca_bus_req_t;

endpackage

/* File: logic/tca_bank.sv */
// Thermal configuration, offset and alert mask register bank
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module tca_bank
  import tca_pkg::*;
#(
  parameter int TEMP_W = 10,                      // Raw temperature width, quarter degrees
  parameter int SINGLE_CHANNEL_MODE_CYCLES = TCA_SINGLE_CHANNEL_MODE_CYCLES,    // Internal conversion spacing
  parameter int AVG_COUNT = TCA_AVG_COUNT         // Conversions per averaged result
) (
  input  wire logic                     ref_clk_i,         // 40 MHz clock
  input  wire logic                     nrst_i,            // Async reset, active low
  input  wire tca_bus_req_t             bus_i,             // Register bus request
  output logic [7:0]                    rdata_o,           // Read data, cycle after read
  input  wire logic                     lock_i,            // Lock bit of first config register
  input  wire logic                     alert_pin_en_i,    // Alert mode of shared pin
  input  wire logic                     ext_single_channel_mode_en_i,     // Test register two bit 2
  input  wire logic                     ext_single_channel_mode_clk_i,    // External conversion clock pin
  input  wire logic [2:0]               chan_sel_i,        // Single channel select code
  input  wire logic                     pwm_polarity_flip_i, // PWM polarity invert
  input  wire logic [TEMP_W-1:0]        local_raw_i,       // Local raw result
  input  wire logic                     local_vld_i,       // Local result strobe
  input  wire logic [TEMP_W-1:0]        remote2_raw_i,     // Remote two raw result
  input  wire logic                     remote2_vld_i,     // Remote two result strobe
  input  wire logic [7:0]               limit_evt_i,       // Out-of-limit events, mask layout
  input  wire logic                     status2_evt_i,     // Any status two condition
  input  wire logic [2:0]               pwm_i,             // PWM levels from fan control
  input  wire logic [2:0][7:0]          duty_i,            // Current duty cycles
  output logic [TEMP_W-1:0]             local_temp_o,      // Corrected local result
  output logic [TEMP_W-1:0]             remote2_temp_o,    // Corrected remote two result
  output logic [3:0]                    two_wire_fan_sel_o, // Two-wire sensing per fan
  output logic                          averaging_enable_o, // Averaging on
  output logic                          input_divider_bypass_o, // Attenuator bypass
  output logic                          single_channel_mode_o,  // Single channel mode
  output logic                          shutdown_enable_o, // Shutdown state
  output logic                          single_channel_mode_start_o,      // Conversion start pulse
  output logic [2:0]                    single_channel_mode_chan_o,       // Channel being converted
  output logic                          single_channel_mode_update_o,     // Result may be updated
  output logic [2:0]                    pwm_o,             // PWM pins, fan-off in shutdown
  output logic                          second_fan_drive_pin_o,    // Shared pin level
  output logic                          second_fan_drive_pin_oe_o, // Low while driven
  output logic [2:0][7:0]               duty_rd_o,         // Duty readback
  output logic                          alert_o,           // Alert condition
  output logic                          irq_o              // Interrupt, level
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Release through two stages, assert at once
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic [7:0] local_offset_reg;
  logic [7:0] remote2_offset_reg;
  logic [7:0] meas_ctrl_reg;
  logic [7:0] alert_mask_reg;
  logic [7:0] limit_status_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic       wr_locked_reg;
  logic       wr_lockable;
  logic       wr_open;

  assign wr_lockable = bus_i.wr && (bus_i.addr == TCA_OFS_LOCAL_OFFSET
                       || bus_i.addr == TCA_OFS_REMOTE2_OFFSET
                       || bus_i.addr == TCA_OFS_MEAS_CTRL);
  // [RL3] lock blocks writes
  assign wr_open = wr_lockable && !lock_i;

  // Offsets and measurement control, all zero after reset
  // [RL15] zero reset values
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      local_offset_reg   <= TCA_RESET_VALUE;
      remote2_offset_reg <= TCA_RESET_VALUE;
      meas_ctrl_reg      <= TCA_RESET_VALUE;
    end else if (wr_open) begin
      case (bus_i.addr)
        TCA_OFS_LOCAL_OFFSET:   local_offset_reg   <= bus_i.wdata;
        TCA_OFS_REMOTE2_OFFSET: remote2_offset_reg <= bus_i.wdata;
        TCA_OFS_MEAS_CTRL:      meas_ctrl_reg      <= bus_i.wdata;
        default: ;
      endcase
    end
  end

  // Alert mask is not lockable; reserved bits 1 and 3 are plain storage
  // [RL14] reserved bits stored
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alert_mask_reg <= TCA_RESET_VALUE;
      irq_mask_reg   <= TCA_RESET_VALUE;
    end else if (bus_i.wr) begin
      if (bus_i.addr == TCA_OFS_ALERT_MASK) begin
        alert_mask_reg <= bus_i.wdata;
      end
      if (bus_i.addr == TCA_OFS_IRQ_MASK) begin
        irq_mask_reg <= bus_i.wdata;
      end
    end
  end

  // Rejected write remembered one cycle for the interrupt
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_locked_reg <= 1'b0;
    end else begin
      wr_locked_reg <= wr_lockable && lock_i;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  // [RL4] fan sensing select
  assign two_wire_fan_sel_o     = meas_ctrl_reg[3:0];
  // [RL6] attenuator bypass
  assign input_divider_bypass_o = meas_ctrl_reg[TCA_BIT_BYPASS];
  assign averaging_enable_o     = meas_ctrl_reg[TCA_BIT_AVG];
  assign single_channel_mode_o  = meas_ctrl_reg[TCA_BIT_SINGLE_CHANNEL_MODE];
  assign shutdown_enable_o      = meas_ctrl_reg[TCA_BIT_SHUTDOWN];

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    TCA_SEQ_25V,
    TCA_SEQ_VCC,
    TCA_SEQ_REM1,
    TCA_SEQ_LOC,
    TCA_SEQ_REM2
  } tca_seq_t;

  tca_seq_t    seq_reg;
  tca_seq_t    seq_next;
  logic [15:0] tick_cnt_reg;
  logic        ext_clk_reg;
  logic        int_tick;
  logic        ext_tick;
  logic        single_channel_mode_tick;
  logic [7:0]  avg_cnt_reg;
  logic        avg_last;
  logic [2:0]  rr_code;

  // Internal conversion rate divider
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 16'h0;
    end else if (int_tick) begin
      tick_cnt_reg <= 16'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h1;
    end
  end
  assign int_tick = (tick_cnt_reg == 16'(SINGLE_CHANNEL_MODE_CYCLES - 1));

  // External clock rising edge, pin taken as synchronous
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_reg <= 1'b0;
    end else begin
      ext_clk_reg <= ext_single_channel_mode_clk_i;
    end
  end
  assign ext_tick = ext_single_channel_mode_clk_i && !ext_clk_reg;

  // [RL9] external clock as conversion source; [RL10] none in shutdown
  assign single_channel_mode_tick = !shutdown_enable_o && (ext_single_channel_mode_en_i ? ext_tick : int_tick);

  // Averaging counts conversions on a channel before it may update
  // [RL5] averaged update
  assign avg_last = !averaging_enable_o || (avg_cnt_reg == 8'(AVG_COUNT - 1));
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avg_cnt_reg <= 8'h0;
    end else if (single_channel_mode_tick) begin
      avg_cnt_reg <= avg_last ? 8'h0 : avg_cnt_reg + 8'h1;
    end
  end

  // Round robin order over the five inputs
  always_comb begin
    case (seq_reg)
      TCA_SEQ_25V:  seq_next = TCA_SEQ_VCC;
      TCA_SEQ_VCC:  seq_next = TCA_SEQ_REM1;
      TCA_SEQ_REM1: seq_next = TCA_SEQ_LOC;
      TCA_SEQ_LOC:  seq_next = TCA_SEQ_REM2;
      default:      seq_next = TCA_SEQ_25V;
    endcase
  end

  always_comb begin
    case (seq_reg)
      TCA_SEQ_25V:  rr_code = TCA_CH_25V;
      TCA_SEQ_VCC:  rr_code = TCA_CH_VCC;
      TCA_SEQ_REM1: rr_code = TCA_CH_REM1;
      TCA_SEQ_LOC:  rr_code = TCA_CH_LOC;
      default:      rr_code = TCA_CH_REM2;
    endcase
  end

  // [RL7] single channel holds the sequence
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= TCA_SEQ_25V;
    end else if (single_channel_mode_tick && avg_last && !single_channel_mode_o) begin
      seq_reg <= seq_next;
    end
  end

  // Start pulse and channel are registered together
  // [RL8] select code drives the channel
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      single_channel_mode_start_o  <= 1'b0;
      single_channel_mode_update_o <= 1'b0;
      single_channel_mode_chan_o   <= TCA_CH_25V;
    end else begin
      single_channel_mode_start_o  <= single_channel_mode_tick;
      single_channel_mode_update_o <= single_channel_mode_tick && avg_last;
      if (single_channel_mode_tick) begin
        single_channel_mode_chan_o <= single_channel_mode_o ? chan_sel_i : rr_code;
      end
    end
  end

  // ----------------------------------------
  // Offset correction
  // ----------------------------------------
  logic [TEMP_W-1:0] local_ofs_ext;
  logic [TEMP_W-1:0] remote2_ofs_ext;

  // Offsets sign extended; sum wraps, no clamping here
  assign local_ofs_ext   = TEMP_W'({{(TEMP_W-8){local_offset_reg[7]}}, local_offset_reg});
  assign remote2_ofs_ext = TEMP_W'({{(TEMP_W-8){remote2_offset_reg[7]}}, remote2_offset_reg});

  // [RL1] [RL2] offset added to results
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      local_temp_o   <= '0;
      remote2_temp_o <= '0;
    end else begin
      if (local_vld_i) begin
        local_temp_o <= local_raw_i + local_ofs_ext;
      end
      if (remote2_vld_i) begin
        remote2_temp_o <= remote2_raw_i + remote2_ofs_ext;
      end
    end
  end

  // ----------------------------------------
  // Limit status and alert
  // ----------------------------------------
  logic rd_limit;
  logic rd_irq;
  logic alert_cause;

  assign rd_limit = bus_i.rd && bus_i.addr == TCA_OFS_LIMIT_STATUS;
  assign rd_irq   = bus_i.rd && bus_i.addr == TCA_OFS_IRQ_STATUS;

  // Sticky regardless of mask; a new event beats the read clear
  // [RL17] status ignores mask
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      limit_status_reg <= TCA_RESET_VALUE;
    end else begin
      limit_status_reg <= (rd_limit ? 8'h00 : limit_status_reg)
                          | (limit_evt_i & TCA_CHAN_MASK_BITS)
                          | {status2_evt_i, 7'h00};
    end
  end

  // [RL12] [RL13] mask gates the alert only
  assign alert_cause = |(limit_status_reg & ~alert_mask_reg & TCA_CHAN_MASK_BITS)
                       || (limit_status_reg[TCA_BIT_MASK_ST2]
                           && !alert_mask_reg[TCA_BIT_MASK_ST2]);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alert_o <= 1'b0;
    end else begin
      alert_o <= alert_cause;
    end
  end

  // ----------------------------------------
  // PWM pins and duty readback
  // ----------------------------------------
  // [RL10] fan-off level follows polarity
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwm_o <= 3'h0;
    end else if (shutdown_enable_o) begin
      pwm_o <= {3{pwm_polarity_flip_i}};
    end else begin
      pwm_o <= pwm_i;
    end
  end

  // Shared pin: open-drain alert, else the second PWM driven both ways
  // [RL16] alert only in alert pin mode
  assign second_fan_drive_pin_o    = alert_pin_en_i ? 1'b0 : pwm_o[1];
  assign second_fan_drive_pin_oe_o = alert_pin_en_i ? !alert_o : 1'b0;

  // [RL11] duty reads zero in shutdown
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      duty_rd_o <= '0;
    end else begin
      duty_rd_o <= shutdown_enable_o ? '0 : duty_i;
    end
  end

  // ----------------------------------------
  // Interrupt status, cleared by reading it
  // ----------------------------------------
  logic [7:0] irq_evt;

  assign irq_evt = {4'h0, (|limit_evt_i) || status2_evt_i, wr_locked_reg,
                    remote2_vld_i, local_vld_i};

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= TCA_RESET_VALUE;
    end else begin
      irq_status_reg <= (rd_irq ? 8'h00 : irq_status_reg) | irq_evt;
    end
  end
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        TCA_OFS_LOCAL_OFFSET:   rdata_o <= local_offset_reg;
        TCA_OFS_REMOTE2_OFFSET: rdata_o <= remote2_offset_reg;
        TCA_OFS_MEAS_CTRL:      rdata_o <= meas_ctrl_reg;
        TCA_OFS_ALERT_MASK:     rdata_o <= alert_mask_reg;
        TCA_OFS_LIMIT_STATUS:   rdata_o <= limit_status_reg;
        TCA_OFS_IRQ_STATUS:     rdata_o <= irq_status_reg;
        TCA_OFS_IRQ_MASK:       rdata_o <= irq_mask_reg;
        default:                rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  property p_lock_hold;
    wr_lockable && lock_i |=> $stable(meas_ctrl_reg) && $stable(local_offset_reg)
                              && $stable(remote2_offset_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked write changed a register"); // [RL3]

  property p_local_sum;
    local_vld_i |=> local_temp_o == TEMP_W'($past(local_raw_i) + $past(local_ofs_ext));
  endproperty
  a_local_sum: assert property (p_local_sum) else $error("local offset sum wrong"); // [RL1]

  property p_remote_sum;
    remote2_vld_i |=> remote2_temp_o == TEMP_W'($past(remote2_raw_i) + $past(remote2_ofs_ext));
  endproperty
  a_remote_sum: assert property (p_remote_sum) else $error("remote offset sum wrong"); // [RL2]

  property p_shutdown_pwm;
    shutdown_enable_o ##1 shutdown_enable_o |-> pwm_o == {3{$past(pwm_polarity_flip_i)}};
  endproperty
  a_shutdown_pwm: assert property (p_shutdown_pwm) else $error("pwm not at fan-off level"); // [RL10]

  property p_shutdown_duty;
    shutdown_enable_o |=> duty_rd_o == '0;
  endproperty
  a_shutdown_duty: assert property (p_shutdown_duty) else $error("duty readback not zero"); // [RL11]

  property p_single_chan;
    single_channel_mode_o && single_channel_mode_tick |=> single_channel_mode_chan_o == $past(chan_sel_i);
  endproperty
  a_single_chan: assert property (p_single_chan) else $error("wrong single channel"); // [RL8]

  property p_masked_quiet;
    (limit_status_reg & ~alert_mask_reg) == 8'h00 |=> !alert_o;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("alert while all masked"); // [RL12]

  property p_status_kept;
    limit_evt_i[TCA_BIT_MASK_LOC] |=> limit_status_reg[TCA_BIT_MASK_LOC];
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("limit status lost"); // [RL17]

  property p_pin_mode;
    !alert_pin_en_i |-> !second_fan_drive_pin_oe_o;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin released in pwm mode"); // [RL16]

  property p_no_single_channel_mode_shutdown;
    shutdown_enable_o |=> !single_channel_mode_start_o;
  endproperty
  a_no_single_channel_mode_shutdown: assert property (p_no_single_channel_mode_shutdown) else $error("conversion in shutdown"); // [RL10]

endmodule

/* File: sim/tca_host_model.sv */
// Management host model driving the register request port
`timescale 1ns/100ps
module tca_host_model
  import tca_pkg::*;
(
  input  wire logic       ref_clk_i, // Bank clock
  input  wire logic [7:0] rdata_i,   // Read data from the bank
  output tca_bus_req_t    bus_o      // Register request
);
  initial bus_o = '0;
  // -------------------------------
  // Bus cycles
  // -------------------------------
  // One-cycle write; lines inverted on release so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    // Step past the edge so callers see the settled register
    #1;
  endtask
  // One-cycle read; data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the thermal configuration and alert mask bank
`timescale 1ns/100ps
module tb_top import tca_pkg::*;;
  logic             ref_clk = 1'b0, nrst = 1'b0, lock = 1'b0, pin_en = 1'b0, pol = 1'b0;
  logic             lvld = 1'b0, rvld = 1'b0, st2 = 1'b0, averaging_enable, byp, single, sdown;
  logic             ext_en = 1'b0, ext_clk = 1'b0;
  logic             cstart, cupd, pin, pin_oe, alert, irq;
  logic [2:0]       csel = 3'h6, pwm = 3'h5, cchan, pwm_q;
  logic [3:0]       fan_sel;
  logic [7:0]       rdata, lim = 8'h00;
  logic [9:0]       lraw = '0, rraw = '0, ltemp, rtemp;
  logic [2:0][7:0]  duty = {8'h30, 8'h20, 8'h10}, duty_q;
  logic [2:0]       codes [5] = '{TCA_CH_25V, TCA_CH_VCC, TCA_CH_REM1, TCA_CH_LOC, TCA_CH_REM2};
  tca_bus_req_t     bus;
  int               error_cnt = 0, comparisons = 0;
  // Short conversion spacing and average count keep the run brief
  tca_bank #(.TEMP_W(10), .SINGLE_CHANNEL_MODE_CYCLES(8), .AVG_COUNT(2)) dut (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .bus_i(bus), .rdata_o(rdata), .lock_i(lock),
    .alert_pin_en_i(pin_en), .ext_single_channel_mode_en_i(ext_en), .ext_single_channel_mode_clk_i(ext_clk),
    .chan_sel_i(csel), .pwm_polarity_flip_i(pol), .local_raw_i(lraw), .local_vld_i(lvld),
    .remote2_raw_i(rraw), .remote2_vld_i(rvld), .limit_evt_i(lim), .status2_evt_i(st2),
    .pwm_i(pwm), .duty_i(duty), .local_temp_o(ltemp), .remote2_temp_o(rtemp),
    .two_wire_fan_sel_o(fan_sel), .averaging_enable_o(averaging_enable), .input_divider_bypass_o(byp),
    .single_channel_mode_o(single), .shutdown_enable_o(sdown), .single_channel_mode_start_o(cstart),
    .single_channel_mode_chan_o(cchan), .single_channel_mode_update_o(cupd), .pwm_o(pwm_q), .second_fan_drive_pin_o(pin),
    .second_fan_drive_pin_oe_o(pin_oe), .duty_rd_o(duty_q), .alert_o(alert), .irq_o(irq));
  tca_host_model host (.ref_clk_i(ref_clk), .rdata_i(rdata), .bus_o(bus));
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  // -------------------------------
  // Shared tasks
  // -------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, d});
  endtask
  // Result strobes for one cycle, corrected value checked the cycle after
  task automatic res(input logic [9:0] l, input logic [9:0] r, input logic lv, input logic rv);
    @(posedge ref_clk);
    lraw <= l;
    rraw <= r;
    lvld <= lv;
    rvld <= rv;
    @(posedge ref_clk);
    lvld <= 1'b0;
    rvld <= 1'b0;
    #1;
  endtask
  task automatic evt(input logic [7:0] l, input logic s);
    @(posedge ref_clk);
    lim <= l;
    st2 <= s;
    @(posedge ref_clk);
    lim <= 8'h00;
    st2 <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Bounded wait for the alert to rise
  task automatic wait_alert();
    for (int i = 0; i < 8 && alert !== 1'b1; i++) @(posedge ref_clk);
    chk("alert raised", 24'h1, {23'h0, alert});
    if (alert !== 1'b1) end_of_test();
  endtask
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // -------------------------------
  // Scenarios
  // -------------------------------
  task automatic s_ctrl();
    host.wr(8'h73, 8'h7a);
    chk("ctrl outs", 24'h00a7, {16'h0, fan_sel, 1'b0, averaging_enable, byp, single});
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) csel <= codes[i];
      repeat (40) @(posedge ref_clk);
      chk("single_channel_mode chan", {21'h0, codes[i]}, {21'h0, cchan});
    end
    host.wr(8'h73, 8'h05);
    chk("ctrl outs", 24'h0050, {16'h0, fan_sel, 1'b0, averaging_enable, byp, single});
    // External clock edge is the only conversion source when selected
    @(posedge ref_clk) ext_en <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 chk("ext idle", 24'h0, {23'h0, cstart});
    @(posedge ref_clk) ext_clk <= 1'b1;
    @(posedge ref_clk);
    #1 chk("ext start", 24'h1, {23'h0, cstart});
    @(posedge ref_clk);
    #1 chk("ext one", 24'h0, {23'h0, cstart});
    @(posedge ref_clk) ext_clk <= 1'b0;
    ext_en <= 1'b0;
  endtask
  // Offsets added as signed quarter-degree steps, wrap on negative result
  task automatic s_offset();
    host.wr(8'ha2, 8'h01);
    rchk(8'ha1, 8'h00);
    host.wr(8'h71, 8'hfc);
    host.wr(8'h72, 8'h05);
    res(10'd100, 10'd10, 1'b1, 1'b1);
    chk("local temp", 24'd96, {14'h0, ltemp});
    chk("remote temp", 24'd15, {14'h0, rtemp});
    chk("irq set", 24'h1, {23'h0, irq});
    rchk(8'ha1, 8'h03);
    chk("irq clear", 24'h0, {23'h0, irq});
    res(10'd2, 10'd0, 1'b1, 1'b0);
    chk("local wrap", 24'h3fe, {14'h0, ltemp});
    rchk(8'ha1, 8'h01);
  endtask
  task automatic s_lock();
    @(posedge ref_clk) lock <= 1'b1;
    host.wr(8'h71, 8'h11);
    host.wr(8'h73, 8'h80);
    rchk(8'h71, 8'hfc);
    rchk(8'h73, 8'h05);
    chk("locked shutdown", 24'h0, {23'h0, sdown});
    rchk(8'ha1, 8'h04);
    host.wr(8'h74, 8'h0a);
    rchk(8'h74, 8'h0a);
    @(posedge ref_clk) lock <= 1'b0;
  endtask
  task automatic s_shutdown();
    @(posedge ref_clk) pol <= 1'b1;
    host.wr(8'h73, 8'h80);
    repeat (2) @(posedge ref_clk);
    chk("pwm off", 24'h7, {21'h0, pwm_q});
    chk("duty rd", 24'h0, duty_q);
    host.wr(8'h73, 8'h00);
    @(posedge ref_clk) pol <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("pwm run", 24'h5, {21'h0, pwm_q});
    chk("duty rd", duty, duty_q);
  endtask
  // Each mask bit blocks only its own channel and never the status bit
  task automatic s_alert();
    logic [7:0] b;
    @(posedge ref_clk) pin_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      b = 8'h01 << (i < 2 ? 2 * i : i + 2);
      host.wr(8'h74, b);
      evt(b & 8'h7f, b[7]);
      chk("alert masked", 24'h0, {23'h0, alert});
      rchk(8'ha0, b);
      host.wr(8'h74, ~b);
      evt(b & 8'h7f, b[7]);
      wait_alert();
      chk("pin", 24'h0, {22'h0, pin, pin_oe});
      rchk(8'ha0, b);
      repeat (3) @(posedge ref_clk);
      chk("alert clear", 24'h0, {23'h0, alert});
    end
  endtask
  // -------------------------------
  // Main sequence
  // -------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int a = 8'h71; a <= 8'h74; a++) rchk(a[7:0], TCA_RESET_VALUE);
    rchk(8'h5a, 8'h00);
    s_ctrl();
    s_offset();
    s_lock();
    s_shutdown();
    s_alert();
    end_of_test();
  end
endmodule
